// [logic/cse_charger_seq.sv]
/*
 * Charger sequencer: trickle, constant current, float with safety timer,
 * bad cell timeout, debounced recharge and thermistor pause; drives the
 * open-drain status pin through the encoder.
 * Assumes comparator flags are clean levels synchronous to clock.
 */
// Overview of operation
// R1 - battery below trickle threshold at cycle start: charge at one tenth current
// R2 - still below trickle after half an hour: stop, unresponsive battery fault
// R3 - battery above trickle threshold: move into full constant-current charging
// R4 - battery reaches float voltage: start the four hour safety timer
// R5 - safety timer expiry: stop charging and stay terminated
// R6 - terminated and battery below recharge threshold: start a new cycle
// R7 - below recharge threshold while timer runs: clear the timer to zero
// R8 - act on below-recharge only after more than 1.3 ms continuous
// R9 - lockout or disable cycling restarts charge cycle and safety timer
// R10 - status pin held low throughout a normal charge cycle
// R11 - at float with current under one tenth: release the status pin
// R12 - ignore the one-tenth indication while input is current limited
// R13 - any fault: 35 kHz carrier with duty blinking low and high
// R14 - temperature fault: 6.25 and 93.75 percent duty at 1.5 Hz
// R15 - bad cell fault: 12.5 and 87.5 percent duty at about 6.1 Hz
// R16 - pause charging while the hot comparator trips
// R17 - pause charging while the cold comparator trips
// R18 - temperature pause in float also freezes the safety timer
// R19 - grounded thermistor pin disables temperature pausing
// R20 - a reader should discard an exact 50 percent duty reading
// R21 - carrier, blink, debounce and timers all count one system clock
`timescale 1ns/1ns
`default_nettype none

module cse_charger_seq
    import cse_pkg::*;
#(
    parameter logic [TIMER_W-1:0] TRICKLE_LIMIT = TIMER_W'(TRICKLE_LIMIT_CYC),
    parameter logic [TIMER_W-1:0] SAFETY_LIMIT  = TIMER_W'(SAFETY_CYC),
    parameter logic [DEB_W-1:0]   DEBOUNCE_LEN  = DEB_W'(DEBOUNCE_CYC),
    parameter logic [BLINK_W-1:0] SLOW_HALF     = BLINK_W'(SLOW_HALF_CYC),
    parameter logic [BLINK_W-1:0] FAST_HALF     = BLINK_W'(FAST_HALF_CYC)
)
(
    // clock and reset
    input  wire logic   clock,
    input  wire logic   rst_n,
    // battery comparators
    input  wire logic   batBelowTrickle,
    input  wire logic   batAtFloat,
    input  wire logic   batBelowRecharge,
    input  wire logic   currentBelowTenth,
    input  wire logic   inputCurrentLimit,
    // thermistor comparators
    input  wire logic   tempHot,
    input  wire logic   tempCold,
    input  wire logic   thermistorGrounded,
    // supply and control
    input  wire logic   supplyLockout,
    input  wire logic   chargerDisable,
    // charger commands
    output var  logic   chargeEnable_r,
    output var  logic   trickleMode_r,
    output var  cse_state_t chargeState_r,
    // open-drain status pin
    output var  logic   chargeStatusOut_r,
    output wire logic   chargeStatusOe
);

    cse_status_if       statusBus();

    cse_state_t         state_nxt;
    logic [TIMER_W-1:0] trickleCnt_r, trickleCnt_nxt;
    logic [TIMER_W-1:0] safetyCnt_r, safetyCnt_nxt;
    logic [DEB_W-1:0]   belowCnt_r, belowCnt_nxt;
    cse_status_mode_t   statusMode_r, statusMode_nxt;
    logic               chargeEnable_nxt;
    logic               trickleMode_nxt;
    logic               active;
    logic               tempPause;
    logic               rechargeEvt;
    logic               chargeDone;
    logic               charging;

    // qualifiers shared by the state logic
    always_comb
    begin
        // R9 lockout or disable holds the cycle off
        active      = !supplyLockout && !chargerDisable;
        // R16 R17 R19 hot or cold pauses unless thermistor grounded
        tempPause   = !thermistorGrounded && (tempHot || tempCold);
        // R12 C/10 ignored in input current limit
        chargeDone  = batAtFloat && currentBelowTenth && !inputCurrentLimit;
    end

    // recharge debounce: counts consecutive low samples
    always_comb
    begin
        if (!batBelowRecharge)
            belowCnt_nxt = '0;
        else if (belowCnt_r == DEBOUNCE_LEN + 1'b1)
            belowCnt_nxt = belowCnt_r;  // saturate so the event fires once
        else
            belowCnt_nxt = belowCnt_r + 1'b1;
        // R8 one pulse once low for more than the debounce time
        rechargeEvt = batBelowRecharge && (belowCnt_r == DEBOUNCE_LEN);
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            belowCnt_r <= '0;
        else
            belowCnt_r <= belowCnt_nxt;
    end

    // sequencer next state and timers
    always_comb
    begin
        state_nxt      = chargeState_r;
        trickleCnt_nxt = trickleCnt_r;
        safetyCnt_nxt  = safetyCnt_r;
        unique case (chargeState_r)
            ST_OFF:
            begin
                trickleCnt_nxt = '0;
                safetyCnt_nxt  = '0;
                if (active)
                    // R1 deep discharge starts in trickle
                    state_nxt = batBelowTrickle ? ST_TRICKLE : ST_CC;
            end
            ST_TRICKLE:
            begin
                if (!batBelowTrickle)
                begin
                    // R3 full current once above threshold
                    state_nxt = ST_CC;
                end
                else if (trickleCnt_r == TRICKLE_LIMIT)
                begin
                    // R2 unresponsive after half an hour
                    state_nxt = ST_BADCELL;
                end
                else if (!tempPause)
                begin
                    // paused time does not count toward bad cell
                    trickleCnt_nxt = trickleCnt_r + 1'b1;
                end
            end
            ST_CC:
            begin
                if (batAtFloat)
                begin
                    // R4 float reached, timer starts from zero
                    state_nxt     = ST_CV;
                    safetyCnt_nxt = '0;
                end
            end
            ST_CV:
            begin
                if (rechargeEvt)
                begin
                    // R7 dip below recharge clears the timer
                    safetyCnt_nxt = '0;
                end
                else if (safetyCnt_r == SAFETY_LIMIT)
                begin
                    // R5 timer expired, terminate
                    state_nxt = ST_DONE;
                end
                else if (!tempPause)
                begin
                    // R18 timer frozen during a temperature pause
                    safetyCnt_nxt = safetyCnt_r + 1'b1;
                end
            end
            ST_DONE:
            begin
                safetyCnt_nxt  = '0;
                trickleCnt_nxt = '0;
                // R6 automatic recharge from terminated
                if (rechargeEvt)
                    state_nxt = batBelowTrickle ? ST_TRICKLE : ST_CC;
            end
            ST_BADCELL:
                state_nxt = ST_BADCELL;  // left only by a restart
            default:
                state_nxt = ST_OFF;
        endcase
        // R9 restart overrides everything
        if (!active)
            state_nxt = ST_OFF;
    end

    // output decode from the next state so outputs match the state register
    always_comb
    begin
        charging         = state_nxt inside {ST_TRICKLE, ST_CC, ST_CV};
        // R5 R16 R17 no current when terminated or paused
        chargeEnable_nxt = charging && !tempPause;
        // R1 one tenth current while trickling
        trickleMode_nxt  = (state_nxt == ST_TRICKLE);
        if (state_nxt == ST_BADCELL)
            statusMode_nxt = MODE_BAD_CELL;          // R15 bad cell pattern
        else if (charging && tempPause)
            statusMode_nxt = MODE_TEMP_FAULT;        // R14 temperature pattern
        else if (state_nxt == ST_CV && chargeDone)
            statusMode_nxt = MODE_RELEASED;          // R11 end of charge shown
        else if (charging)
            statusMode_nxt = MODE_LOW;               // R10 charging held low
        else
            statusMode_nxt = MODE_RELEASED;
    end

    // state and output registers
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chargeState_r     <= ST_OFF;
            trickleCnt_r      <= '0;
            safetyCnt_r       <= '0;
            chargeEnable_r    <= 1'b0;
            trickleMode_r     <= 1'b0;
            statusMode_r      <= MODE_RELEASED;
            chargeStatusOut_r <= 1'b0;
        end
        else
        begin
            chargeState_r     <= state_nxt;
            trickleCnt_r      <= trickleCnt_nxt;
            safetyCnt_r       <= safetyCnt_nxt;
            chargeEnable_r    <= chargeEnable_nxt;
            trickleMode_r     <= trickleMode_nxt;
            statusMode_r      <= statusMode_nxt;
            chargeStatusOut_r <= 1'b0;  // open drain only ever drives low
        end
    end

    assign statusBus.mode = statusMode_r;

    // R21 encoder counts the same system clock
    cse_status_encoder #(
        .SLOW_HALF (SLOW_HALF),
        .FAST_HALF (FAST_HALF)
    ) u_encoder (
        .clock (clock),
        .rst_n (rst_n),
        .stat  (statusBus.enc),
        .pinOe (chargeStatusOe)
    );

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_trickle_current: assert property (
        chargeState_r == ST_TRICKLE |-> trickleMode_r) // R1
        else $error("trickle state without reduced current");
    a_badcell_timeout: assert property (
        chargeState_r == ST_TRICKLE && trickleCnt_r == TRICKLE_LIMIT && batBelowTrickle && active
        |=> chargeState_r == ST_BADCELL && !chargeEnable_r) // R2
        else $error("bad cell timeout not taken");
    a_cc_entry: assert property (
        chargeState_r == ST_TRICKLE && !batBelowTrickle && active
        |=> chargeState_r == ST_CC && !trickleMode_r) // R3
        else $error("trickle did not advance to full current");
    a_timer_start: assert property (
        chargeState_r == ST_CC && batAtFloat && active
        |=> chargeState_r == ST_CV && safetyCnt_r == '0) // R4
        else $error("safety timer not started at float");
    a_done_no_current: assert property (
        chargeState_r == ST_DONE |-> !chargeEnable_r && statusMode_r == MODE_RELEASED) // R5
        else $error("current flows after termination");
    a_recharge_restart: assert property (
        chargeState_r == ST_DONE && rechargeEvt && active
        |=> chargeState_r inside {ST_TRICKLE, ST_CC}) // R6
        else $error("recharge did not restart the cycle");
    a_timer_clear: assert property (
        chargeState_r == ST_CV && rechargeEvt && active |=> safetyCnt_r == '0) // R7
        else $error("safety timer not cleared on recharge dip");
    a_debounce_len: assert property (
        rechargeEvt
        |-> $past(batBelowRecharge, 1) && $past(belowCnt_r, 1) == DEBOUNCE_LEN - 1'b1) // R8
        else $error("recharge acted on before debounce time");
    a_restart_off: assert property (
        !active |=> chargeState_r == ST_OFF && !chargeEnable_r) // R9
        else $error("lockout or disable did not stop the cycle");
    a_limit_no_release: assert property (
        chargeState_r == ST_CV && inputCurrentLimit && !tempPause && active
        && safetyCnt_r != SAFETY_LIMIT
        |=> statusMode_r == MODE_LOW) // R12
        else $error("end of charge shown in current limit");
    a_float_freeze: assert property (
        chargeState_r == ST_CV && tempPause && active && !rechargeEvt
        |=> $stable(safetyCnt_r) && !chargeEnable_r) // R18
        else $error("safety timer ran during temperature pause");

    c_bad_cell: cover property (chargeState_r == ST_BADCELL);
    c_terminated: cover property (chargeState_r == ST_CV ##1 chargeState_r == ST_DONE);
    c_recharge: cover property (chargeState_r == ST_DONE ##1 chargeState_r == ST_CC);
    c_temp_pause: cover property (statusMode_r == MODE_TEMP_FAULT);

endmodule

`default_nettype wire

// [logic/cse_pkg.sv]
/*
 * Shared constants and types for the charger sequencer and its status encoder.
 * Assumes a single free-running 25 MHz system clock feeding every counter.
 */
`default_nettype none

package cse_pkg;

    // system clock
    localparam longint CLK_HZ            = 64'd25_000_000;

    // times in their own units
    localparam longint TRICKLE_LIMIT_S   = 64'd1800;       // half an hour
    localparam longint SAFETY_TIME_S     = 64'd14400;      // four hours
    localparam longint DEBOUNCE_TIME_NS  = 64'd1_300_000;  // 1.3 ms
    localparam longint CARRIER_HZ        = 64'd35_000;
    localparam longint SLOW_BLINK_MHZ    = 64'd1500;       // 1.5 Hz, in millihertz
    localparam longint FAST_BLINK_MHZ    = 64'd6100;       // 6.1 Hz, in millihertz
    localparam longint DUTY_STEPS        = 64'd16;         // 6.25 % resolution

    // derived cycle counts
    localparam longint TRICKLE_LIMIT_CYC = TRICKLE_LIMIT_S * CLK_HZ;
    localparam longint SAFETY_CYC        = SAFETY_TIME_S * CLK_HZ;
    localparam longint DEBOUNCE_CYC      = (DEBOUNCE_TIME_NS * CLK_HZ + 64'd999_999_999)
                                           / 64'd1_000_000_000;
    localparam longint SLICE_CYC         = CLK_HZ / (CARRIER_HZ * DUTY_STEPS);
    localparam longint SLOW_HALF_CYC     = (CLK_HZ * 64'd1000) / (64'd2 * SLOW_BLINK_MHZ);
    localparam longint FAST_HALF_CYC     = (CLK_HZ * 64'd1000) / (64'd2 * FAST_BLINK_MHZ);

    // counter widths and sized forms
    localparam int          TIMER_W      = 40;
    localparam int          DEB_W        = 16;
    localparam int          BLINK_W      = 24;
    localparam logic [5:0]  SLICE_LAST   = 6'(SLICE_CYC - 64'd1);

    // duty cycles in sixteenths of a carrier period (pin pulled low)
    localparam logic [3:0]  TEMP_DIM     = 4'h1;  // 6.25 %
    localparam logic [3:0]  TEMP_BRIGHT  = 4'hf;  // 93.75 %
    localparam logic [3:0]  BAD_DIM      = 4'h2;  // 12.5 %
    localparam logic [3:0]  BAD_BRIGHT   = 4'he;  // 87.5 %

    // sequencer states
    typedef enum logic [2:0] {
        ST_OFF,
        ST_TRICKLE,
        ST_CC,
        ST_CV,
        ST_DONE,
        ST_BADCELL
    } cse_state_t;

    // status pin patterns
    typedef enum logic [1:0] {
        MODE_LOW,
        MODE_RELEASED,
        MODE_TEMP_FAULT,
        MODE_BAD_CELL
    } cse_status_mode_t;

endpackage

`default_nettype wire

// [logic/cse_status_if.sv]
/*
 * Carries the requested status pattern from the sequencer to the encoder.
 * Both ends sit on the same system clock.
 */
`timescale 1ns/1ns
`default_nettype none

interface cse_status_if;
    import cse_pkg::*;

    cse_status_mode_t mode;

    modport seq (output mode);
    modport enc (input mode);
endinterface

`default_nettype wire

// [logic/cse_status_encoder.sv]
/*
 * Status pin encoder: solid low, released, or a 35 kHz carrier whose duty
 * cycle blinks between two values. Assumes mode is registered by its source.
 */
`timescale 1ns/1ns
`default_nettype none

module cse_status_encoder
    import cse_pkg::*;
#(
    parameter logic [BLINK_W-1:0] SLOW_HALF = BLINK_W'(SLOW_HALF_CYC),
    parameter logic [BLINK_W-1:0] FAST_HALF = BLINK_W'(FAST_HALF_CYC)
)
(
    // clock and reset
    input  wire logic   clock,
    input  wire logic   rst_n,
    // requested pattern
    cse_status_if.enc   stat,
    // open-drain enable, high pulls the pin low
    output var  logic   pinOe
);

    logic [5:0]         sliceCnt_r, sliceCnt_nxt;
    logic [3:0]         phase_r, phase_nxt;
    logic [BLINK_W-1:0] blinkCnt_r, blinkCnt_nxt;
    logic               bright_r, bright_nxt;
    logic               pinOe_nxt;
    logic [BLINK_W-1:0] halfLast;
    logic [3:0]         duty;

    // free-running carrier and blink counters; no restart on mode change
    always_comb
    begin
        halfLast     = (stat.mode == MODE_BAD_CELL) ? FAST_HALF - 1'b1 : SLOW_HALF - 1'b1;
        sliceCnt_nxt = (sliceCnt_r == SLICE_LAST) ? 6'h00 : sliceCnt_r + 6'h01;
        phase_nxt    = (sliceCnt_r == SLICE_LAST) ? phase_r + 4'h1 : phase_r;
        blinkCnt_nxt = blinkCnt_r + 1'b1;
        bright_nxt   = bright_r;
        // >= so a shorter half after a mode change still wraps at once
        if (blinkCnt_r >= halfLast)
        begin
            blinkCnt_nxt = '0;
            bright_nxt   = ~bright_r;
        end
        // R14 R15 two duty levels
        if (stat.mode == MODE_BAD_CELL)
            duty = bright_r ? BAD_BRIGHT : BAD_DIM;
        else
            duty = bright_r ? TEMP_BRIGHT : TEMP_DIM;
        // R13 carrier on faults
        unique case (stat.mode)
            MODE_LOW:        pinOe_nxt = 1'b1;
            MODE_RELEASED:   pinOe_nxt = 1'b0;
            MODE_TEMP_FAULT: pinOe_nxt = (phase_r < duty);
            MODE_BAD_CELL:   pinOe_nxt = (phase_r < duty);
        endcase
    end

    // registers
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sliceCnt_r <= 6'h00;
            phase_r    <= 4'h0;
            blinkCnt_r <= '0;
            bright_r   <= 1'b0;
            pinOe      <= 1'b0;
        end
        else
        begin
            sliceCnt_r <= sliceCnt_nxt;
            phase_r    <= phase_nxt;
            blinkCnt_r <= blinkCnt_nxt;
            bright_r   <= bright_nxt;
            pinOe      <= pinOe_nxt;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_low_pin_held: assert property ((stat.mode == MODE_LOW) |=> pinOe) // R10
        else $error("status pin not pulled low while charging");
    a_fault_first_slice: assert property (
        (stat.mode inside {MODE_TEMP_FAULT, MODE_BAD_CELL}) && phase_r == 4'h0 |=> pinOe) // R13
        else $error("fault carrier missing its low slice");
    a_bad_dim_edge: assert property (
        (stat.mode == MODE_BAD_CELL) && !bright_r && phase_r == 4'h2 |=> !pinOe) // R15
        else $error("bad cell dim duty too long");
    c_bright_flip: cover property ((stat.mode == MODE_TEMP_FAULT) && $rose(bright_r));

endmodule

`default_nettype wire

// [sim/cse_pin_model.sv]
/*
 * Status pin load: pull-up resistor and a pulse-width reader.
 * Assumes the block pulls the pin low only while its enable is high.
 */
`timescale 1ns/1ns
`default_nettype none

module cse_pin_model
    import cse_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // pin drive from the block
    input  wire logic        pinOe,
    input  wire logic        pinOut,
    input  wire logic        clearStats,
    // resolved level and pulse statistics
    output var  logic        pinLevel,
    output var  logic [15:0] minLow,
    output var  logic [15:0] maxLow
);
    logic [15:0] runLen;
    logic        skipOne;

    // pull-up wins whenever the block lets go
    always_comb pinLevel = pinOe ? pinOut : 1'b1;

    // low pulse lengths; first pulse after a clear may be partial
    // exact half-carrier reading discarded
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n || clearStats)
        begin
            runLen <= 16'h0;
            minLow <= 16'hffff;
            maxLow <= 16'h0;
            skipOne <= 1'b1;
        end
        else if (!pinLevel)
            runLen <= runLen + 16'h1;
        else if (runLen != 16'h0)
        begin
            runLen <= 16'h0;
            skipOne <= 1'b0;
            if (!skipOne && runLen != 16'(SLICE_LAST + 6'h1) * 16'h8)
            begin
                minLow <= (runLen < minLow) ? runLen : minLow;
                maxLow <= (runLen > maxLow) ? runLen : maxLow;
            end
        end
    end
endmodule

`default_nettype wire

// [sim/tb.sv]
/*
 * Self-checking bench for the charger sequencer with short timers.
 * Assumes comparator flags change just after a rising clock edge.
 */
`timescale 1ns/1ns
`default_nettype none

module tb;
    import cse_pkg::*;

    logic        clock;
    logic        rst_n;
    logic        batBelowTrickle;
    logic        batAtFloat;
    logic        batBelowRecharge;
    logic        currentBelowTenth;
    logic        inputCurrentLimit;
    logic        tempHot;
    logic        tempCold;
    logic        thermistorGrounded;
    logic        supplyLockout;
    logic        chargerDisable;
    logic        chargeEnable_r;
    logic        trickleMode_r;
    cse_state_t  chargeState_r;
    logic        chargeStatusOut_r;
    logic        chargeStatusOe;
    logic        clearStats;
    logic        pinLevel;
    logic [15:0] minLow;
    logic [15:0] maxLow;
    int          miscompares;
    int          checkCount;

    // slice length of the status carrier
    localparam logic [15:0] SLICE = 16'(SLICE_LAST + 6'h1);

    // short timers keep the run brief; blink halves span whole carriers
    cse_charger_seq #(.TRICKLE_LIMIT(40'd200), .SAFETY_LIMIT(40'd300),
        .DEBOUNCE_LEN(16'd10), .SLOW_HALF(24'd2816), .FAST_HALF(24'd1408))
    cse_charger_seq_i (.clock(clock), .rst_n(rst_n), .batBelowTrickle(batBelowTrickle),
        .batAtFloat(batAtFloat), .batBelowRecharge(batBelowRecharge),
        .currentBelowTenth(currentBelowTenth), .inputCurrentLimit(inputCurrentLimit),
        .tempHot(tempHot), .tempCold(tempCold), .thermistorGrounded(thermistorGrounded),
        .supplyLockout(supplyLockout), .chargerDisable(chargerDisable),
        .chargeEnable_r(chargeEnable_r), .trickleMode_r(trickleMode_r),
        .chargeState_r(chargeState_r), .chargeStatusOut_r(chargeStatusOut_r),
        .chargeStatusOe(chargeStatusOe));

    cse_pin_model cse_pin_model_i (.clock(clock), .rst_n(rst_n), .pinOe(chargeStatusOe),
        .pinOut(chargeStatusOut_r), .clearStats(clearStats), .pinLevel(pinLevel),
        .minLow(minLow), .maxLow(maxLow));

    // 25 MHz
    always #20 clock = ~clock;

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic report(input logic [15:0] got, input logic [15:0] exp);
        checkCount++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkBit(input logic got, input logic exp);
        report({15'h0, got}, {15'h0, exp});
    endtask

    task automatic chkState(input cse_state_t got, input cse_state_t exp);
        report({13'h0, got}, {13'h0, exp});
    endtask

    task automatic chkWidth(input logic [15:0] got, input logic [15:0] exp);
        report(got, exp);
    endtask

    // bounded wait for a state, then judge it
    task automatic waitState(input cse_state_t exp, input int limit);
        int n;
        n = 0;
        while (chargeState_r !== exp && n < limit)
        begin
            tick(1);
            n++;
        end
        chkState(chargeState_r, exp);
    endtask

    task automatic doReset(input logic lowCell);
        rst_n = 1'b0;
        batBelowTrickle = lowCell;
        {batAtFloat, batBelowRecharge, currentBelowTenth, inputCurrentLimit} = 4'h0;
        {tempHot, tempCold, thermistorGrounded, supplyLockout, chargerDisable} = 5'h0;
        clearStats = 1'b0;
        tick(4);
        rst_n = 1'b1;
    endtask

    task automatic restartStats();
        clearStats = 1'b1;
        tick(1);
        clearStats = 1'b0;
    endtask

    task automatic testTrickle();
        doReset(1'b1);
        tick(1);
        chkState(chargeState_r, ST_TRICKLE);
        chkBit(trickleMode_r, 1'b1);
        tick(1);
        chkBit(pinLevel, 1'b0);
        tick(185);
        chkState(chargeState_r, ST_TRICKLE);
        waitState(ST_BADCELL, 30);
        chkBit(chargeEnable_r, 1'b0);
        restartStats();
        tick(3620);
        chkWidth(minLow, SLICE * 16'(BAD_DIM));
        chkWidth(maxLow, SLICE * 16'(BAD_BRIGHT));
        supplyLockout = 1'b1;
        batBelowTrickle = 1'b0;
        tick(2);
        chkState(chargeState_r, ST_OFF);
        supplyLockout = 1'b0;
        tick(2);
        chkState(chargeState_r, ST_CC);
        $display("test trickle and bad cell finished");
    endtask

    task automatic testCharge();
        doReset(1'b1);
        tick(3);
        batBelowTrickle = 1'b0;
        tick(1);
        chkState(chargeState_r, ST_CC);
        chkBit(trickleMode_r, 1'b0);
        batAtFloat = 1'b1;
        tick(1);
        chkState(chargeState_r, ST_CV);
        currentBelowTenth = 1'b1;
        inputCurrentLimit = 1'b1;
        tick(3);
        chkBit(pinLevel, 1'b0);
        inputCurrentLimit = 1'b0;
        tick(3);
        chkBit(pinLevel, 1'b1);
        currentBelowTenth = 1'b0;
        tick(94);
        // a short dip must leave the timer running
        batBelowRecharge = 1'b1;
        tick(5);
        batBelowRecharge = 1'b0;
        tick(180);
        chkState(chargeState_r, ST_CV);
        waitState(ST_DONE, 30);
        chkBit(chargeEnable_r, 1'b0);
        batAtFloat = 1'b0;
        batBelowRecharge = 1'b1;
        tick(5);
        batBelowRecharge = 1'b0;
        tick(3);
        chkState(chargeState_r, ST_DONE);
        batBelowRecharge = 1'b1;
        waitState(ST_CC, 20);
        batBelowRecharge = 1'b0;
        tick(1);
        chkBit(pinLevel, 1'b0);
        batAtFloat = 1'b1;
        tick(200);
        batBelowRecharge = 1'b1;
        tick(15);
        batBelowRecharge = 1'b0;
        tick(265);
        chkState(chargeState_r, ST_CV);
        waitState(ST_DONE, 60);
        batAtFloat = 1'b0;
        batBelowRecharge = 1'b1;
        waitState(ST_CC, 20);
        batBelowRecharge = 1'b0;
        batAtFloat = 1'b1;
        tick(51);
        tempHot = 1'b1;
        tick(2);
        chkBit(chargeEnable_r, 1'b0);
        tick(98);
        tempHot = 1'b0;
        tick(200);
        chkState(chargeState_r, ST_CV);
        waitState(ST_DONE, 80);
        $display("test charge cycle finished");
    endtask

    task automatic testTemperature();
        doReset(1'b0);
        tick(3);
        tempCold = 1'b1;
        tick(2);
        chkBit(chargeEnable_r, 1'b0);
        restartStats();
        tick(6400);
        chkWidth(minLow, SLICE * 16'(TEMP_DIM));
        chkWidth(maxLow, SLICE * 16'(TEMP_BRIGHT));
        thermistorGrounded = 1'b1;
        tick(2);
        chkBit(chargeEnable_r, 1'b1);
        tick(1);
        chkBit(pinLevel, 1'b0);
        chargerDisable = 1'b1;
        tick(2);
        chkState(chargeState_r, ST_OFF);
        chargerDisable = 1'b0;
        tick(2);
        chkState(chargeState_r, ST_CC);
        $display("test temperature finished");
    endtask

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // watchdog: tests need roughly half a millisecond
    initial
    begin
        #1_500_000;
        miscompares++;
        $display("watchdog expired at %0t ns", $time);
        summarize();
    end

    initial
    begin
        clock = 1'b0;
        miscompares = 0;
        checkCount = 0;
        doReset(1'b1);
        testTrickle();
        testCharge();
        testTemperature();
        summarize();
    end
endmodule

`default_nettype wire
